// ===== hdl/lsl_top.v
// serial on-off shift register, latch and blanked sink outputs of a 24-channel driver
`timescale 1ns/1ps
`include "lsl_defs.vh"
module lsl_top
#(
  parameter SHIFT_LEN = `LSL_SHIFT_LEN,
  parameter GROUP_LEN = `LSL_GROUP_LEN
)
(
  // clock and reset
  input  wire                 CLK,
  input  wire                 ARST_N,
  // serial link pins
  input  wire                 SHIFT_CLOCK,
  input  wire                 SERIAL_IN,
  input  wire                 LATCH_STROBE,
  input  wire                 OUTPUT_BLANK,
  output reg                  SERIAL_OUT,
  // sink enables, high means sink on
  output reg  [GROUP_LEN-1:0] RED_SINKS,
  output reg  [GROUP_LEN-1:0] GREEN_SINKS,
  output reg  [GROUP_LEN-1:0] BLUE_SINKS
);

  // channels held in the on-off latch: three colour groups
  localparam CHAN_NUM = 3 * GROUP_LEN;

  // filtered pin levels
  wire                 sclk_s;
  wire                 din_s;
  wire                 lat_s;
  wire                 blank_s;
  // filtered levels one clock ago, and the rising edges found from them
  reg                  sclk_q;
  reg                  lat_q;
  wire                 sclk_rise;
  wire                 lat_rise;
  // common shift register, its next value and the next serial output
  reg  [SHIFT_LEN-1:0] shift_q;
  wire [SHIFT_LEN-1:0] shift_d;
  wire                 serial_out_d;
  // on-off latch and its next value
  reg  [CHAN_NUM-1:0]  latch_q;
  wire [CHAN_NUM-1:0]  latch_d;
  // blank-gated channels and the three colour groups taken from them
  wire [CHAN_NUM-1:0]  sink_d;
  wire [GROUP_LEN-1:0] red_d;
  wire [GROUP_LEN-1:0] green_d;
  wire [GROUP_LEN-1:0] blue_d;

  // one colour group out of a channel vector, lowest channel first
  function [GROUP_LEN-1:0] group_bits;
    input [CHAN_NUM-1:0] vec;
    input integer        pos;
    begin
      group_bits = vec[pos +: GROUP_LEN];
    end
  endfunction

  // shift clock pin; its filter delay is matched by the data pin below
  lsl_sync u_sclk
  (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .pin_in  (SHIFT_CLOCK),
    .level_q (sclk_s)
  );

  // serial data pin through the same stages, so the bit at the clock edge is taken
  lsl_sync u_din
  (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .pin_in  (SERIAL_IN),
    .level_q (din_s)
  );

  // latch strobe pin
  lsl_sync u_lat
  (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .pin_in  (LATCH_STROBE),
    .level_q (lat_s)
  );

  // blank pin; a pulse must last two clocks to pass the agreement filter
  lsl_sync u_blnk
  (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .pin_in  (OUTPUT_BLANK),
    .level_q (blank_s)
  );

  // rising edges of the filtered levels; idle pins are low, as after reset
  assign sclk_rise = sclk_s & ~sclk_q;
  assign lat_rise  = lat_s & ~lat_q;

  // previous filtered levels for the edge detectors
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sclk_q <= 1'b0;
      lat_q  <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk_s;
      lat_q  <= lat_s;
    end
  end

  // next shift register: serial_in enters bit zero
  assign shift_d[0] = sclk_rise ? din_s : shift_q[0];

  // next shift register: every other bit takes the one below it
  genvar b;
  generate
    for (b = 1; b < SHIFT_LEN; b = b + 1)
    begin : g_shift
      assign shift_d[b] = sclk_rise ? shift_q[b-1] : shift_q[b];
    end
  endgenerate

  // serial_out follows the new top bit, for the next driver in the chain
  assign serial_out_d = sclk_rise ? shift_q[SHIFT_LEN-2] : SERIAL_OUT;

  // a latch edge takes the lower bits; the top bit only feeds serial_out
  assign latch_d = lat_rise ? shift_q[CHAN_NUM-1:0] : latch_q;

  // common shift register
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      shift_q <= `LSL_SHIFT_RST;
    end
    else
    begin
      shift_q <= shift_d;
    end
  end

  // serial output register
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      SERIAL_OUT <= 1'b0;
    end
    else
    begin
      SERIAL_OUT <= serial_out_d;
    end
  end

  // on-off latch register, one bit per channel
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      latch_q <= `LSL_LATCH_RST;
    end
    else
    begin
      latch_q <= latch_d;
    end
  end

  // blank gating per channel
  genvar i;
  generate
    for (i = 0; i < CHAN_NUM; i = i + 1)
    begin : g_gate
      assign sink_d[i] = latch_q[i] & ~blank_s;
    end
  endgenerate

  // split the gated channels into the colour groups
  assign red_d   = group_bits(sink_d, `LSL_RED_POS);
  assign green_d = group_bits(sink_d, `LSL_GREEN_POS);
  assign blue_d  = group_bits(sink_d, `LSL_BLUE_POS);

  // red group output register
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      RED_SINKS <= {GROUP_LEN{1'b0}};
    end
    else
    begin
      RED_SINKS <= red_d;
    end
  end

  // green group output register
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      GREEN_SINKS <= {GROUP_LEN{1'b0}};
    end
    else
    begin
      GREEN_SINKS <= green_d;
    end
  end

  // blue group output register
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      BLUE_SINKS <= {GROUP_LEN{1'b0}};
    end
    else
    begin
      BLUE_SINKS <= blue_d;
    end
  end

endmodule // lsl_top

// ===== inc/lsl_defs.vh
// constants for the led on-off shift and latch block
`ifndef LSL_DEFS_VH
`define LSL_DEFS_VH
`define LSL_SHIFT_LEN   25
`define LSL_CHAN_NUM    24
`define LSL_GROUP_LEN   8
`define LSL_RED_POS     0
`define LSL_GREEN_POS   8
`define LSL_BLUE_POS    16
`define LSL_SHIFT_RST   25'h0000000
`define LSL_LATCH_RST   24'h000000
`endif

// ===== hdl/lsl_sync.v
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module lsl_sync
(
  // clock and reset
  input  wire clk,
  input  wire arst_n,
  // pin and filtered level
  input  wire pin_in,
  output reg  level_q
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // the first stage feeds only the second; level moves once stages two and three agree
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        level_q <= s3_q;
    end
  end

endmodule // lsl_sync

// ===== tb/lsl_sva.sv
// sink and serial output checks
`timescale 1ns/1ps
module lsl_sva #(parameter GROUP_LEN=8)(input wire CLK,ARST_N,SHIFT_CLOCK,LATCH_STROBE,
 OUTPUT_BLANK,SERIAL_OUT,input wire [GROUP_LEN-1:0] RED_SINKS,GREEN_SINKS,BLUE_SINKS);
  wire [3*GROUP_LEN-1:0] k={BLUE_SINKS,GREEN_SINKS,RED_SINKS};
  wire z=k==0;
  default clocking @(posedge CLK);endclocking
  default disable iff(!ARST_N);
  sequence s_calm;($stable(OUTPUT_BLANK)&&$stable(LATCH_STROBE))[*8];endsequence
  property p_1;OUTPUT_BLANK[*8]|->z;endproperty
  a_1:assert property(p_1)else $error("lit");
  property p_2;$rose(OUTPUT_BLANK)|->##[2:8]z;endproperty
  a_2:assert property(p_2)else $error("lit");
  property p_3;s_calm|=>$stable(k);endproperty
  a_3:assert property(p_3)else $error("moved");
  property p_4;($stable(LATCH_STROBE)&&!OUTPUT_BLANK)[*8]|=>$stable(k);endproperty
  a_4:assert property(p_4)else $error("moved");
  property p_5;$fell(LATCH_STROBE)|->##1 $stable(k)[*8];endproperty
  a_5:assert property(p_5)else $error("moved");
  property p_6;$stable(SHIFT_CLOCK)[*8]|=>$stable(SERIAL_OUT);endproperty
  a_6:assert property(p_6)else $error("out");
  property p_7;$fell(SHIFT_CLOCK)|->##1 $stable(SERIAL_OUT)[*8];endproperty
  a_7:assert property(p_7)else $error("out");
  property p_8;$rose(ARST_N)|->z&&!SERIAL_OUT;endproperty
  a_8:assert property(p_8)else $error("reset");
endmodule // lsl_sva
bind lsl_top lsl_sva #(.GROUP_LEN(GROUP_LEN)) u_sva(.CLK(CLK),.ARST_N(ARST_N),
 .SHIFT_CLOCK(SHIFT_CLOCK),.LATCH_STROBE(LATCH_STROBE),.OUTPUT_BLANK(OUTPUT_BLANK),
 .SERIAL_OUT(SERIAL_OUT),.RED_SINKS(RED_SINKS),.GREEN_SINKS(GREEN_SINKS),.BLUE_SINKS(BLUE_SINKS));

// ===== tb/lsl_host.sv
// host model shifting frames
`timescale 1ns/1ps
module lsl_host(output reg k=0,d=0,l=0);
  integer i;
  // msb first, data set mid low phase
  task send(input [24:0] v);for(i=24;i>=0;i--)begin d=v[i];#40 k=1;#80 k=0;#40;end endtask
  // latch pulse well after last shift
  task latch;begin #100 l=1;#100 l=0;#100;end endtask
endmodule // lsl_host

// ===== tb/tb_lsl_top.sv
// frame bench: an all-ones frame, an all-zeros frame, then random frames
`timescale 1ns/1ps
module tb_lsl_top;
  reg c=0,a=0,q=0;
  wire s,d,l,o;
  wire [7:0] r,g,b;
  integer seed=32'hd71f88eb,fails=0,check_count=0,t=0,n;
  reg [24:0] v,p=0;
  lsl_host h(.k(s),.d(d),.l(l));
  lsl_top dut(.CLK(c),.ARST_N(a),.SHIFT_CLOCK(s),.SERIAL_IN(d),.LATCH_STROBE(l),
   .OUTPUT_BLANK(q),.SERIAL_OUT(o),.RED_SINKS(r),.GREEN_SINKS(g),.BLUE_SINKS(b));
  initial forever #2.5 c=~c;
  task ck(input [24:0] x,e);begin check_count++;if(x!==e)begin fails++;
   $display("BAD %0t seen %h expected %h",$time,x,e);end end endtask
  // expected pins: top shift bit on serial out, latch gated by blank
  function [24:0] ex(input [24:0] s,input [23:0] m,input z);ex={s[24],z?24'h0:m};endfunction
  task stop_test;begin $display("%0d/%0d",fails,check_count);
   if(!fails&&check_count)$display("No errors found");else $display("Errors were found");
   $finish;end endtask
  task w;begin repeat(10)@(posedge c);#1;end endtask
  always@(posedge c)if(++t>9999)begin fails++;stop_test;end
  initial begin
   repeat(2)@(posedge c);#1 a=1;
   for(n=0;n<6;n++)begin
    v=n<1?-1:n<2?0:$random(seed);
    h.send(v);w;ck({o,b,g,r},ex(v,p[23:0],0));
    h.latch;w;ck({o,b,g,r},ex(v,v[23:0],0));
    q=1;w;ck({o,b,g,r},ex(v,v[23:0],1));
    q=0;w;p=v;$display("frame %0d",n);
   end
   stop_test;
  end
endmodule // tb_lsl_top
